// File: sgp_map.svh
// register offsets, field positions, reset values and timing counts for the standby io port
// assumes a byte-wide register access path inside the wake-up controller
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// ==========================================
// config bank offsets (bank 3)
`define SGP_OFS_INDEX      8'h13
`define SGP_OFS_CONFIG     8'h14
// runtime offsets relative to the port base
`define SGP_OFS_DOUT0      3'h0
`define SGP_OFS_DIN0       3'h1
`define SGP_OFS_DOUT1      3'h2
`define SGP_OFS_DIN1       3'h3

// ==========================================
// field positions
`define SGP_CFG_OE         0
`define SGP_CFG_OTYPE      1
`define SGP_CFG_PULLUP     2
`define SGP_CFG_LOCK       3
`define SGP_CFG_ETYPE      4
`define SGP_CFG_EPOL       5
`define SGP_CFG_DEB        6
`define SGP_IDX_PORT       4

// ==========================================
// reset values and write masks
`define SGP_RST_CFG_EV     8'h44
`define SGP_RST_CFG_OUT    8'h05
`define SGP_RST_CFG_IN     8'h40
`define SGP_RST_INDEX      8'h00
`define SGP_RST_DOUT       8'h00
`define SGP_IDX_MASK       8'h17
`define SGP_CFG_EV_MASK    8'h7f
`define SGP_CFG_OUT_MASK   8'h0f
`define SGP_CFG_IN_MASK    8'h70

// ==========================================
// timing: debounce period
`define SGP_CLK_HZ         40000000
`define SGP_DEB_MS         15
`define SGP_DEB_CYCLES     ((`SGP_CLK_HZ / 1000) * `SGP_DEB_MS)

`endif

// File: sgp_pkg.sv
// types shared by the standby io port
// assumes the map header provides all numbers
package sgp_pkg;
	typedef logic [7:0] sgp_byte_type;
	typedef enum logic [1:0] {
		SGP_DEB_IDLE,
		SGP_DEB_WAIT
	} sgp_deb_state_type;
endpackage

// File: sgp_event_pin.sv
// one pin's debouncer and event detector
// assumes the pin level is already synchronised to i_clk
`include "sgp_map.svh"

module sgp_event_pin #(
	parameter int unsigned DEB_CYCLES = `SGP_DEB_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_level,
	input  wire logic i_deb_en,
	input  wire logic i_level_mode,
	input  wire logic i_polarity,
	input  wire logic i_clear,
	output logic      o_pending
);
	typedef struct packed {
		sgp_pkg::sgp_deb_state_type state;
		logic [23:0]                count;
		logic                       filt;
		logic                       filt_d;
		logic                       sticky;
	} sgp_ev_state_type;

	localparam logic [23:0] LAST = 24'(DEB_CYCLES - 1);

	sgp_ev_state_type st_reg;
	sgp_ev_state_type st_next;
	logic             det_in;
	logic             det_prev;
	logic             edge_hit;

	// ==========================================
	// debounce then detect
	always_comb begin
		st_next = st_reg;
		unique case (st_reg.state)
			sgp_pkg::SGP_DEB_IDLE: begin
				if (i_level != st_reg.filt) begin
					st_next.state = sgp_pkg::SGP_DEB_WAIT;
					st_next.count = '0;
				end
			end
			sgp_pkg::SGP_DEB_WAIT: begin
				if (i_level == st_reg.filt) begin
					st_next.state = sgp_pkg::SGP_DEB_IDLE; // bounced back
				end else if (st_reg.count == LAST) begin
					st_next.filt  = i_level;
					st_next.state = sgp_pkg::SGP_DEB_IDLE;
				end else begin
					st_next.count = st_reg.count + 24'h000001;
				end
			end
			default: st_next.state = sgp_pkg::SGP_DEB_IDLE; // unused code recovers
		endcase
		det_in           = i_deb_en ? st_reg.filt : i_level;
		det_prev         = st_reg.filt_d;
		st_next.filt_d   = det_in;
		edge_hit = (det_in != det_prev) && (det_in == i_polarity);
		if (edge_hit && !i_level_mode) begin
			st_next.sticky = 1'b1; // set wins over clear
		end else if (i_clear) begin
			st_next.sticky = 1'b0;
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '{state: sgp_pkg::SGP_DEB_IDLE, count: 24'h000000,
				filt: 1'b0, filt_d: 1'b0, sticky: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// level mode follows active level, edge mode is sticky
	assign o_pending = i_level_mode ? (st_reg.filt_d == i_polarity) : st_reg.sticky;
endmodule

// File: sgp_standby_io_port.sv
// standby io port: config bank, runtime data registers, pins, event pending
// assumes byte-wide single-cycle register strobes from the wake-up controller
`include "sgp_map.svh"

module sgp_standby_io_port #(
	parameter int unsigned DEB_CYCLES = `SGP_DEB_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ctrl_active,
	input  wire logic       i_cfg_wr,
	input  wire logic       i_cfg_rd,
	input  wire logic [7:0] i_cfg_addr,
	input  wire logic [7:0] i_cfg_wdata,
	output logic      [7:0] o_cfg_rdata,
	input  wire logic       i_rt_wr,
	input  wire logic       i_rt_rd,
	input  wire logic [2:0] i_rt_addr,
	input  wire logic [7:0] i_rt_wdata,
	output logic      [7:0] o_rt_rdata,
	input  wire logic [5:0] i_bidir_pins,
	output logic      [5:0] o_bidir_pins,
	output logic      [5:0] o_bidir_pins_oe_n,
	output logic      [5:0] o_bidir_pullup,
	input  wire logic [1:0] i_event_inputs,
	input  wire logic [1:0] i_plain_inputs,
	output logic      [1:0] o_output_pins,
	output logic      [1:0] o_output_pins_oe_n,
	output logic      [1:0] o_output_pullup,
	input  wire logic [7:0] i_event_clear,
	output logic      [7:0] o_event_pending
);
	typedef struct packed {
		logic [7:0][7:0] cfg0;  // port 0 pin config
		logic [1:0][7:0] cfg1;  // port 1 output pin config
		logic [7:0]      index;
		logic [7:0]      dout0;
		logic [7:0]      dout1;
		logic [7:0]      cfg_rdata;
		logic [7:0]      rt_rdata;
		logic [9:0]      sync1;
		logic [9:0]      sync2;
	} sgp_top_state_type;

	sgp_top_state_type st_reg;
	sgp_top_state_type st_next;
	logic              sel_port;
	logic [2:0]        sel_pin;
	logic [7:0]        sel_cfg;
	logic [7:0]        wmask;
	logic [7:0]        din0;
	logic [7:0]        din1;
	logic              out_drv [8];
	logic              out_oe [8];

	// ==========================================
	// index decode
	assign sel_port = st_reg.index[`SGP_IDX_PORT];
	assign sel_pin  = st_reg.index[2:0];

	// input levels seen by software and detectors
	assign din0 = st_reg.sync2[7:0];
	assign din1 = {2'b00, st_reg.sync2[9:8], st_reg.dout1[1:0]};

	// currently indexed config register
	always_comb begin
		sel_cfg = 8'h00;
		if (!sel_port) begin
			sel_cfg = st_reg.cfg0[sel_pin];
		end else if (sel_pin < 3'h2) begin
			sel_cfg = st_reg.cfg1[sel_pin[0]];
		end
	end

	// ==========================================
	// register writes and reads
	always_comb begin
		st_next       = st_reg;
		st_next.sync1 = {i_plain_inputs, i_event_inputs, i_bidir_pins};
		st_next.sync2 = st_reg.sync1;
		// lock freezes bits 0-3, lock itself is set only
		wmask = sel_cfg[`SGP_CFG_LOCK] ? 8'hf0 : 8'hff;
		if (i_cfg_wr && i_cfg_addr == `SGP_OFS_INDEX) begin
			st_next.index = i_cfg_wdata & `SGP_IDX_MASK;
		end
		if (i_cfg_wr && i_cfg_addr == `SGP_OFS_CONFIG) begin
			if (!sel_port) begin
				st_next.cfg0[sel_pin] = ((sel_cfg & ~wmask) | (i_cfg_wdata & wmask))
					& (sel_pin < 3'h6 ? `SGP_CFG_EV_MASK : `SGP_CFG_IN_MASK);
			end else if (sel_pin < 3'h2) begin
				st_next.cfg1[sel_pin[0]] = ((sel_cfg & ~wmask) | (i_cfg_wdata & wmask))
					& `SGP_CFG_OUT_MASK;
			end
		end
		// runtime access only while controller active
		if (i_rt_wr && i_ctrl_active) begin
			for (int i = 0; i < 8; i++) begin
				if (i_rt_addr == `SGP_OFS_DOUT0 && !st_reg.cfg0[i][`SGP_CFG_LOCK]) begin
					st_next.dout0[i] = i_rt_wdata[i];
				end
			end
			for (int i = 0; i < 2; i++) begin
				if (i_rt_addr == `SGP_OFS_DOUT1 && !st_reg.cfg1[i][`SGP_CFG_LOCK]) begin
					st_next.dout1[i] = i_rt_wdata[i];
				end
			end
		end
		st_next.cfg_rdata = 8'h00;
		if (i_cfg_rd) begin
			if (i_cfg_addr == `SGP_OFS_INDEX) begin
				st_next.cfg_rdata = st_reg.index;
			end else if (i_cfg_addr == `SGP_OFS_CONFIG) begin
				st_next.cfg_rdata = sel_cfg;
			end
		end
		st_next.rt_rdata = 8'h00;
		if (i_rt_rd && i_ctrl_active) begin
			unique case (i_rt_addr)
				`SGP_OFS_DOUT0: st_next.rt_rdata = st_reg.dout0;
				`SGP_OFS_DIN0:  st_next.rt_rdata = din0;
				`SGP_OFS_DOUT1: st_next.rt_rdata = {6'h00, st_reg.dout1[1:0]};
				`SGP_OFS_DIN1:  st_next.rt_rdata = din1;
				default:        st_next.rt_rdata = 8'h00;
			endcase
		end
	end

	// ==========================================
	// state register; pin config reset per pin type
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg.cfg0      <= {`SGP_RST_CFG_IN, `SGP_RST_CFG_IN, {6{`SGP_RST_CFG_EV}}};
			st_reg.cfg1      <= {2{`SGP_RST_CFG_OUT}};
			st_reg.index     <= `SGP_RST_INDEX;
			st_reg.dout0     <= `SGP_RST_DOUT;
			st_reg.dout1     <= `SGP_RST_DOUT;
			st_reg.cfg_rdata <= 8'h00;
			st_reg.rt_rdata  <= 8'h00;
			st_reg.sync1     <= 10'h000;
			st_reg.sync2     <= 10'h000;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// pin drivers: oe from bit 0, open drain drives low only
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i < 6) begin
				out_oe[i]  = st_reg.cfg0[i][`SGP_CFG_OE]
					&& (st_reg.cfg0[i][`SGP_CFG_OTYPE] || !st_reg.dout0[i]);
				out_drv[i] = st_reg.dout0[i];
			end else begin
				out_oe[i]  = st_reg.cfg1[i - 6][`SGP_CFG_OE]
					&& (st_reg.cfg1[i - 6][`SGP_CFG_OTYPE] || !st_reg.dout1[i - 6]);
				out_drv[i] = st_reg.dout1[i - 6];
			end
		end
	end

	// pin outputs and pull-ups
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			o_bidir_pins[i]      = out_drv[i];
			o_bidir_pins_oe_n[i] = !out_oe[i];
			o_bidir_pullup[i]    = st_reg.cfg0[i][`SGP_CFG_PULLUP];
		end
		for (int i = 0; i < 2; i++) begin
			o_output_pins[i]      = out_drv[i + 6];
			o_output_pins_oe_n[i] = !out_oe[i + 6];
			o_output_pullup[i]    = st_reg.cfg1[i][`SGP_CFG_PULLUP];
		end
	end

	assign o_cfg_rdata = st_reg.cfg_rdata;
	assign o_rt_rdata  = st_reg.rt_rdata;

	// ==========================================
	// event detectors on port 0 only
	generate
		for (genvar g = 0; g < 8; g++) begin : g_ev
			sgp_event_pin #(.DEB_CYCLES (DEB_CYCLES)) u_ev (
				.i_clk        (i_clk),
				.i_rst        (i_rst),
				.i_level      (din0[g]),
				.i_deb_en     (st_reg.cfg0[g][`SGP_CFG_DEB]),
				.i_level_mode (st_reg.cfg0[g][`SGP_CFG_ETYPE]),
				.i_polarity   (st_reg.cfg0[g][`SGP_CFG_EPOL]),
				.i_clear      (i_event_clear[g]),
				.o_pending    (o_event_pending[g])
			);
		end
	endgenerate
endmodule

// File: sgp_port_monitor.sv
// checker on the standby io port pins and strobes
// assumes one clock, one-cycle strobes, two input sync stages
module sgp_port_monitor (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_ctrl_active,
	input wire logic       i_cfg_wr,
	input wire logic       i_cfg_rd,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic       i_rt_wr,
	input wire logic       i_rt_rd,
	input wire logic [2:0] i_rt_addr,
	input wire logic [7:0] o_rt_rdata,
	input wire logic [1:0] i_plain_inputs,
	input wire logic [5:0] o_bidir_pins,
	input wire logic [5:0] o_bidir_pins_oe_n,
	input wire logic [5:0] o_bidir_pullup,
	input wire logic [1:0] o_output_pins,
	input wire logic [1:0] o_output_pullup
);
	// ==========
	timeunit 1ns;
	timeprecision 1ps;
	// read data and pins
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_cfg_idle; !i_cfg_rd |=> o_cfg_rdata == 8'h00; endproperty
	a_cfg_idle: assert property (p_cfg_idle) else $error("cfg rdata");
	property p_rt_idle; !i_rt_rd |=> o_rt_rdata == 8'h00; endproperty
	a_rt_idle: assert property (p_rt_idle) else $error("rt rdata");
	property p_gate; i_rt_rd && !i_ctrl_active |=> o_rt_rdata == 8'h00; endproperty
	a_gate: assert property (p_gate) else $error("gated read");
	property p_unmap; i_rt_rd && i_rt_addr > 3'h3 |=> o_rt_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_plain; i_rt_rd && i_ctrl_active && i_rt_addr == 3'h3
		&& $stable(i_plain_inputs) && $past(i_plain_inputs, 2) == i_plain_inputs
		|=> o_rt_rdata[3:2] == $past(i_plain_inputs); endproperty
	a_plain: assert property (p_plain) else $error("plain level");
	property p_pull; !i_cfg_wr |=> $stable(o_bidir_pullup) && $stable(o_output_pullup); endproperty
	a_pull: assert property (p_pull) else $error("pull-up moved");
	property p_drive; !i_cfg_wr && !i_rt_wr |=> $stable({o_bidir_pins_oe_n, o_bidir_pins});
	endproperty
	a_drive: assert property (p_drive) else $error("drive moved");
	property p_idle; !i_ctrl_active && !i_cfg_wr |=> $stable({o_bidir_pins, o_output_pins});
	endproperty
	a_idle: assert property (p_idle) else $error("idle pins moved");
endmodule

bind sgp_standby_io_port sgp_port_monitor u_mon (
	.i_clk, .i_rst, .i_ctrl_active, .i_cfg_wr, .i_cfg_rd, .o_cfg_rdata, .i_rt_wr, .i_rt_rd,
	.i_rt_addr, .o_rt_rdata, .i_plain_inputs, .o_bidir_pins, .o_bidir_pins_oe_n,
	.o_bidir_pullup, .o_output_pins, .o_output_pullup
);

// File: sgp_pin_partner.sv
// outside parts on the bidir pins: drivers, pull-ups, open lines
// assumes oe_n low means the port drives the pin
module sgp_pin_partner (
	input  wire logic       i_clk,
	input  wire logic [5:0] i_drive,
	input  wire logic [5:0] i_oe_n,
	input  wire logic [5:0] i_pullup,
	input  wire logic [5:0] i_ext_en,
	input  wire logic [5:0] i_ext_val,
	output logic      [5:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flt_reg = 1'b0;
	// ==========
	// an open line wanders every cycle
	always @(posedge i_clk) flt_reg <= ~flt_reg;
	// port first, then outside driver, then pull-up
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			if (!i_oe_n[k])
				o_level[k] = i_drive[k];
			else if (i_ext_en[k])
				o_level[k] = i_ext_val[k];
			else
				o_level[k] = i_pullup[k] | flt_reg;
		end
	end
endmodule

// File: sgp_standby_io_port_tb_top.sv
// bench for the standby io port: register calls with expected values
// assumes 40 MHz clock and the pin partner on the bidir pins
module sgp_standby_io_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clk = 1'b0, i_rst = 1'b1, i_ctrl_active = 1'b1;
	logic       i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_rt_wr = 1'b0, i_rt_rd = 1'b0;
	logic [7:0] i_cfg_addr = 8'h00, i_cfg_wdata = 8'h00, i_rt_wdata = 8'h00, i_event_clear = 8'h00;
	logic [7:0] o_cfg_rdata, o_rt_rdata, o_event_pending, q;
	logic [2:0] i_rt_addr = 3'h0;
	logic [5:0] i_bidir_pins, o_bidir_pins, o_bidir_pins_oe_n, o_bidir_pullup;
	logic [5:0] ext_en = 6'h00, ext_val = 6'h00;
	logic [1:0] i_event_inputs = 2'b11, i_plain_inputs = 2'b10;
	logic [1:0] o_output_pins, o_output_pins_oe_n, o_output_pullup;
	int         n_errors = 0, checks_done = 0, cyc = 0;

	// short debounce period so the filter is seen within the run
	sgp_standby_io_port #(.DEB_CYCLES(32)) DUT (
		.i_clk, .i_rst, .i_ctrl_active, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata,
		.o_cfg_rdata, .i_rt_wr, .i_rt_rd, .i_rt_addr, .i_rt_wdata, .o_rt_rdata, .i_bidir_pins,
		.o_bidir_pins, .o_bidir_pins_oe_n, .o_bidir_pullup, .i_event_inputs, .i_plain_inputs,
		.o_output_pins, .o_output_pins_oe_n, .o_output_pullup, .i_event_clear, .o_event_pending
	);
	sgp_pin_partner u_far (
		.i_clk(i_clk), .i_drive(o_bidir_pins), .i_oe_n(o_bidir_pins_oe_n),
		.i_pullup(o_bidir_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_bidir_pins)
	);

	// ==========
	// clock, hang guard, bus tasks
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			complete_run();
		end
	end
	// one access, strobe held across one rising edge
	task automatic acc(input bit cfg, input bit wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_cfg_addr = a;
		i_rt_addr = a[2:0];
		i_cfg_wdata = d;
		i_rt_wdata = d;
		i_cfg_wr = cfg & wr;
		i_cfg_rd = cfg & !wr;
		i_rt_wr = !cfg & wr;
		i_rt_rd = !cfg & !wr;
		@(negedge i_clk);
		q = cfg ? o_cfg_rdata : o_rt_rdata;
		i_cfg_wr = 1'b0;
		i_cfg_rd = 1'b0;
		i_rt_wr = 1'b0;
		i_rt_rd = 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input bit cfg, input logic [7:0] a, input logic [7:0] exp);
		acc(cfg, 1'b0, a, 8'h00);
		chk(q, exp);
	endtask
	// pending clear pulse with settling on both sides
	task automatic clr(input logic [7:0] m);
		repeat (4) @(negedge i_clk);
		i_event_clear = m;
		@(negedge i_clk);
		i_event_clear = 8'h00;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic complete_run();
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========
	// test sequence
	initial begin
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		rdc(1, 8'h13, 8'h00);
		rdc(1, 8'h14, 8'h44);
		acc(1, 1, 8'h13, 8'h06);
		rdc(1, 8'h14, 8'h40);
		acc(1, 1, 8'h13, 8'h10);
		rdc(1, 8'h14, 8'h05);
		acc(1, 1, 8'h13, 8'hff);
		rdc(1, 8'h13, 8'h17);
		// pin 0 push-pull, then open drain
		acc(1, 1, 8'h13, 8'h00);
		acc(1, 1, 8'h14, 8'h03);
		acc(0, 1, 8'h00, 8'h01);
		chk({2'b00, o_bidir_pins_oe_n}, 8'h3e);
		chk({2'b00, o_bidir_pullup}, 8'h3e);
		chk({2'b00, o_bidir_pins}, 8'h01);
		acc(1, 1, 8'h14, 8'h05);
		chk({2'b00, o_bidir_pins_oe_n}, 8'h3f);
		acc(0, 1, 8'h00, 8'h20);
		chk({2'b00, o_bidir_pins_oe_n}, 8'h3e);
		acc(0, 1, 8'h00, 8'h21);
		ext_en = 6'h3c;
		ext_val = 6'h14;
		repeat (4) @(negedge i_clk);
		rdc(0, 8'h01, 8'hd7);
		acc(0, 1, 8'h01, 8'h00);
		rdc(0, 8'h01, 8'hd7);
		rdc(0, 8'h00, 8'h21);
		// port 1 outputs and plain inputs; open drain drives only a low
		acc(0, 1, 8'h02, 8'h02);
		chk({6'h00, o_output_pins_oe_n}, 8'h02);
		chk({6'h00, o_output_pins}, 8'h02);
		chk({6'h00, o_output_pullup}, 8'h03);
		acc(0, 0, 8'h03, 8'h00);
		chk(q & 8'h0c, 8'h08);
		// lock pin 1
		acc(1, 1, 8'h13, 8'h01);
		acc(1, 1, 8'h14, 8'h0b);
		acc(1, 1, 8'h14, 8'h70);
		rdc(1, 8'h14, 8'h7b);
		acc(0, 1, 8'h00, 8'h23);
		rdc(0, 8'h00, 8'h21);
		// inactive controller, unmapped place
		i_ctrl_active = 1'b0;
		acc(0, 1, 8'h00, 8'h00);
		rdc(0, 8'h00, 8'h00);
		i_ctrl_active = 1'b1;
		rdc(0, 8'h00, 8'h21);
		rdc(0, 8'h05, 8'h00);
		// pin 6: falling, rising, low, high with debounce off
		acc(1, 1, 8'h13, 8'h06);
		for (int m = 0; m < 4; m++) begin
			i_event_inputs[0] = !m[0];
			acc(1, 1, 8'h14, {2'b00, m[0], m[1], 4'h0});
			clr(8'h40);
			chk(o_event_pending & 8'h40, 8'h00);
			i_event_inputs[0] = m[0];
			repeat (6) @(negedge i_clk);
			chk(o_event_pending & 8'h40, 8'h40);
			i_event_inputs[0] = !m[0];
			repeat (6) @(negedge i_clk);
			chk(o_event_pending & 8'h40, m[1] ? 8'h00 : 8'h40);
			clr(8'h40);
			chk(o_event_pending & 8'h40, 8'h00);
		end
		// pin 7 keeps its debounce from reset: fall seen only after the period
		i_event_inputs[1] = 1'b0;
		repeat (20) @(negedge i_clk);
		chk(o_event_pending & 8'h80, 8'h00);
		repeat (40) @(negedge i_clk);
		chk(o_event_pending & 8'h80, 8'h80);
		clr(8'h80);
		chk(o_event_pending & 8'h80, 8'h00);
		// a glitch shorter than the period never reaches the detector
		i_event_inputs[1] = 1'b1;
		repeat (10) @(negedge i_clk);
		i_event_inputs[1] = 1'b0;
		repeat (60) @(negedge i_clk);
		chk(o_event_pending & 8'h80, 8'h00);
		complete_run();
	end
endmodule
